/* verilog/cgsr_top.sv */
// two-wire target and control outputs of the clock generator
`timescale 1ns/100ps
module cgsr_top import cgsr_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // two-wire bus, data is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // straps and control pins
    input wire logic addr_strap_i,
    input wire logic [1:0] spread_pin_i,
    input wire logic output_enable_pin_n_i,
    input wire logic power_down_n_i,
    // clock path controls
    output logic [11:0] pcie_out_en_o,
    output logic [7:0] pcie_edge_fast_o,
    output logic [1:0] spread_code_o,
    output logic refclk_en_o,
    output logic [1:0] refclk_edge_rate_o
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD, ST_CNT, ST_ACK_CNT,
        ST_WDAT, ST_ACK_WDAT, ST_TX, ST_RX_ACK, ST_IGNORE
    } cgsr_state_t;

    logic scl_s;
    logic sda_s;
    logic strap_s;
    logic [1:0] spread_s;
    logic oe_pin_n_s;
    logic pd_n_s;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // all pins pass the agreeing synchroniser; idle bus levels are high
    cgsr_pin_sync #(.W(7)) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .pin_i({scl_i, sda_i, addr_strap_i, spread_pin_i, output_enable_pin_n_i, power_down_n_i}),
        .rst_val_i(7'h7F),
        .level_o({scl_s, sda_s, strap_s, spread_s, oe_pin_n_s, pd_n_s})
    );

    // bus edge and condition detection from filtered levels
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // strap capture: waits for the synchroniser, then holds until the next reset
    logic captured;
    logic [1:0] cap_cnt;
    logic strap_cap;
    logic [1:0] spread_cap;
    logic next_captured;
    logic [1:0] next_cap_cnt;
    logic next_strap_cap;
    logic [1:0] next_spread_cap;
    logic [6:0] dev_addr;

    always_comb begin
        next_captured = captured;
        next_cap_cnt = cap_cnt;
        next_strap_cap = strap_cap;
        next_spread_cap = spread_cap;
        if (!captured) begin
            if (cap_cnt == STRAP_SETTLE) begin
                next_captured = 1'b1;
                next_strap_cap = strap_s;
                next_spread_cap = spread_s;
            end else begin
                next_cap_cnt = cap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            captured <= 1'b0;
            cap_cnt <= 2'h0;
            strap_cap <= 1'b0;
            spread_cap <= 2'h0;
        end else begin
            captured <= next_captured;
            cap_cnt <= next_cap_cnt;
            strap_cap <= next_strap_cap;
            spread_cap <= next_spread_cap;
        end
    end

    assign dev_addr = strap_cap ? ADDR_STRAP_HI : ADDR_STRAP_LO;

    // register bank
    logic wr_en;
    logic [6:0] idx;
    logic [7:0] shift;
    logic [7:0] rd_data;
    logic [11:0] en_bits;
    logic spread_src;
    logic [1:0] spread_sw;
    logic ref_oe;
    logic ref_keep;
    logic [1:0] ref_rate;
    logic [7:0] slew;

    cgsr_regs u_regs (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(wr_en),
        .wr_idx_i(idx),
        .wr_data_i(shift),
        .rd_idx_i(idx),
        .rd_data_o(rd_data),
        .spread_pin_i(spread_cap),
        .en_o(en_bits),
        .spread_src_o(spread_src),
        .spread_sw_o(spread_sw),
        .ref_oe_o(ref_oe),
        .ref_keep_o(ref_keep),
        .ref_rate_o(ref_rate),
        .slew_o(slew)
    );

    // protocol engine state
    cgsr_state_t state;
    cgsr_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] next_shift;
    logic [7:0] tx_sh;
    logic [7:0] next_tx_sh;
    logic [6:0] next_idx;
    logic single;
    logic next_single;
    logic rw;
    logic next_rw;
    logic [7:0] wr_left;
    logic [7:0] next_wr_left;
    logic cnt_ok;
    logic next_cnt_ok;
    logic host_nack;
    logic next_host_nack;
    logic next_sda_oe;

    // byte engine; ack bits span from one scl fall to the next
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_tx_sh = tx_sh;
        next_idx = idx;
        next_single = single;
        next_rw = rw;
        next_wr_left = wr_left;
        next_cnt_ok = cnt_ok;
        next_host_nack = host_nack;
        wr_en = 1'b0;
        if (!captured || stop_det) begin
            next_state = ST_IDLE;
        end else if (start_det) begin
            // repeated start keeps the index from the command
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
        end else begin
            case (state)
                ST_ADDR, ST_CMD, ST_CNT, ST_WDAT: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                        next_bit_cnt = 4'h0;
                        case (state)
                            ST_ADDR: begin
                                if (shift[7:1] == dev_addr) begin
                                    next_rw = shift[0];
                                    next_state = ST_ACK_ADDR;
                                end else begin
                                    next_state = ST_IGNORE;
                                end
                            end
                            ST_CMD: begin
                                next_idx = shift[6:0];
                                next_single = shift[7];
                                next_state = ST_ACK_CMD;
                            end
                            ST_CNT: begin
                                next_wr_left = shift;
                                next_cnt_ok = (shift != 8'h00) && (shift < BLK_WR_LIMIT);
                                next_state = ST_ACK_CNT;
                            end
                            default: begin
                                // bytes past a bad or spent count are acked but dropped
                                if (single) begin
                                    wr_en = 1'b1;
                                end else if (cnt_ok && wr_left != 8'h00) begin
                                    wr_en = 1'b1;
                                    next_wr_left = wr_left - 8'h01;
                                    next_idx = idx + 7'h01;
                                end
                                next_state = ST_ACK_WDAT;
                            end
                        endcase
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall && rw) begin
                        next_state = ST_TX;
                        if (single) begin
                            next_tx_sh = rd_data;
                            next_idx = idx + 7'h01;
                        end else begin
                            next_tx_sh = BLK_RD_COUNT;
                        end
                    end else if (scl_fall) begin
                        next_state = ST_CMD;
                    end
                end
                ST_ACK_CMD: begin
                    if (scl_fall) begin
                        next_state = single ? ST_WDAT : ST_CNT;
                    end
                end
                ST_ACK_CNT: begin
                    if (scl_fall) begin
                        next_state = ST_WDAT;
                    end
                end
                ST_ACK_WDAT: begin
                    if (scl_fall) begin
                        next_state = single ? ST_IGNORE : ST_WDAT;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                        next_bit_cnt = 4'h0;
                        next_state = ST_RX_ACK;
                    end else if (scl_fall) begin
                        next_tx_sh = {tx_sh[6:0], 1'b0};
                    end
                end
                ST_RX_ACK: begin
                    if (scl_rise) begin
                        next_host_nack = sda_s;
                    end else if (scl_fall && host_nack) begin
                        next_state = ST_IGNORE;
                    end else if (scl_fall) begin
                        next_state = ST_TX;
                        next_tx_sh = rd_data;
                        next_idx = idx + 7'h01;
                    end
                end
                default: next_state = state;
            endcase
        end
        // drive low for our acks and for zero data bits only
        next_sda_oe = (next_state == ST_ACK_ADDR) || (next_state == ST_ACK_CMD) ||
                      (next_state == ST_ACK_CNT) || (next_state == ST_ACK_WDAT) ||
                      (next_state == ST_TX && !next_tx_sh[7]);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx_sh <= 8'h00;
            idx <= 7'h00;
            single <= 1'b0;
            rw <= 1'b0;
            wr_left <= 8'h00;
            cnt_ok <= 1'b0;
            host_nack <= 1'b0;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            tx_sh <= next_tx_sh;
            idx <= next_idx;
            single <= next_single;
            rw <= next_rw;
            wr_left <= next_wr_left;
            cnt_ok <= next_cnt_ok;
            host_nack <= next_host_nack;
            sda_oe_o <= next_sda_oe;
            sda_o <= 1'b0;
        end
    end

    // clock path controls, all registered; power-down stops the PCIe outputs and, unless keep is set, the reference
    logic [11:0] next_out_en;
    logic [1:0] next_spread;
    logic next_ref_en;

    always_comb begin
        next_out_en = en_bits & {12{!oe_pin_n_s && pd_n_s}};
        next_spread = spread_src ? spread_sw : spread_cap;
        next_ref_en = ref_oe && (pd_n_s || ref_keep);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pcie_out_en_o <= 12'h000;
            pcie_edge_fast_o <= SLEW_RST;
            spread_code_o <= 2'h0;
            refclk_en_o <= 1'b0;
            refclk_edge_rate_o <= REF_RATE_RST;
        end else begin
            pcie_out_en_o <= next_out_en;
            pcie_edge_fast_o <= slew;
            spread_code_o <= next_spread;
            refclk_en_o <= next_ref_en;
            refclk_edge_rate_o <= ref_rate;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_addr_match_ack: assert property (
        (state == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS && shift[7:1] == dev_addr && !start_det && !stop_det)
        |=> (state == ST_ACK_ADDR) && sda_oe_o)
        else $error("own address not acknowledged");
    a_strap_held: assert property (
        (captured && $past(captured)) |-> $stable(dev_addr))
        else $error("target address changed after capture");
    a_block_step: assert property (
        (wr_en && !single) |=> idx == $past(idx) + 7'h01)
        else $error("block write did not step the index");
    a_cmd_index: assert property (
        (state == ST_CMD && scl_fall && bit_cnt == BYTE_BITS && !start_det && !stop_det)
        |=> idx == $past(shift[6:0]) && single == $past(shift[7]))
        else $error("command code not taken as index and mode");
    a_count_first: assert property (
        (state == ST_ACK_ADDR && rw && !single && scl_fall && !start_det && !stop_det)
        |=> tx_sh == BLK_RD_COUNT)
        else $error("block read did not start with the count");
    a_nack_ends: assert property (
        (state == ST_RX_ACK && host_nack && scl_fall && !start_det && !stop_det)
        |=> state == ST_IGNORE ##1 !sda_oe_o)
        else $error("transmission continued after host nack");
    a_tx_bit_drive: assert property (
        (state == ST_TX) |-> sda_oe_o == !tx_sh[7])
        else $error("data line does not follow transmit bit");
    a_out_gate: assert property (
        (oe_pin_n_s || !pd_n_s) |=> pcie_out_en_o == 12'h000)
        else $error("output enabled while pin disables it");
    a_ref_powerdown: assert property (
        (!pd_n_s && !ref_keep) |=> !refclk_en_o)
        else $error("reference runs in power-down without keep");
    a_spread_source: assert property (
        (!spread_src && captured) |=> spread_code_o == $past(spread_cap))
        else $error("pin spread setting not applied");
    a_single_write: assert property (
        (state == ST_WDAT && single && scl_fall && bit_cnt == BYTE_BITS && !start_det && !stop_det)
        |-> wr_en ##1 state == ST_ACK_WDAT)
        else $error("byte write not stored and acked");
endmodule : cgsr_top

/* verilog/cgsr_pkg.sv */
// constants shared by the clock generator serial control block
package cgsr_pkg;
    // target addresses selected by the captured strap
    localparam logic [6:0] ADDR_STRAP_LO = 7'h69;
    localparam logic [6:0] ADDR_STRAP_HI = 7'h6A;
    // register byte indices
    localparam logic [6:0] IDX_EN_LO = 7'h00;
    localparam logic [6:0] IDX_EN_HI = 7'h01;
    localparam logic [6:0] IDX_REF_CTRL = 7'h02;
    localparam logic [6:0] IDX_SLEW = 7'h03;
    // field positions
    localparam int EN_HI_LSB = 4;
    localparam int SPREAD_SRC_BIT = 7;
    localparam int SPREAD_SW_LSB = 5;
    localparam int REF_OE_BIT = 3;
    localparam int REF_KEEP_BIT = 2;
    localparam int REF_RATE_LSB = 0;
    // reset values
    localparam logic [7:0] EN_LO_RST = 8'hFF;
    localparam logic [3:0] EN_HI_RST = 4'hF;
    localparam logic SPREAD_SRC_RST = 1'h0;
    localparam logic [1:0] SPREAD_SW_RST = 2'h1;
    localparam logic REF_OE_RST = 1'h1;
    localparam logic REF_KEEP_RST = 1'h0;
    localparam logic [1:0] REF_RATE_RST = 2'h1;
    localparam logic [7:0] SLEW_RST = 8'hFF;
    // block transfer counts
    localparam logic [7:0] BLK_RD_COUNT = 8'h04;
    localparam logic [7:0] BLK_WR_LIMIT = 8'h07;
    // cycles waited after reset before straps are trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // bus bits per byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage : cgsr_pkg

/* verilog/cgsr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cgsr_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // pins and filtered levels
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic next_level;
            // a change counts only once stages two and three agree
            always_comb begin
                next_level = (s2[g] == s3[g]) ? s3[g] : level_o[g];
            end
            // stages run through reset so the pin level is already valid at release;
            // the level resets to the pin's idle value, so no false edge follows reset
            always_ff @(posedge clk_i) begin
                s1[g] <= pin_i[g];
                s2[g] <= s1[g];
                s3[g] <= s2[g];
                if (!reset_n_i) begin
                    level_o[g] <= rst_val_i[g];
                end else begin
                    level_o[g] <= next_level;
                end
            end
        end
    endgenerate
endmodule : cgsr_pin_sync

/* verilog/cgsr_regs.sv */
// control register bytes with one write port and one read port
`timescale 1ns/100ps
module cgsr_regs import cgsr_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // access port
    input wire logic wr_en_i,
    input wire logic [6:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [6:0] rd_idx_i,
    output logic [7:0] rd_data_o,
    // captured spread pins
    input wire logic [1:0] spread_pin_i,
    // fields
    output logic [11:0] en_o,
    output logic spread_src_o,
    output logic [1:0] spread_sw_o,
    output logic ref_oe_o,
    output logic ref_keep_o,
    output logic [1:0] ref_rate_o,
    output logic [7:0] slew_o
);
    logic [11:0] next_en;
    logic next_src;
    logic [1:0] next_sw;
    logic next_ref_oe;
    logic next_ref_keep;
    logic [1:0] next_ref_rate;
    logic [7:0] next_slew;

    // writes land on whole bytes; reserved bits have no storage
    always_comb begin
        next_en = en_o;
        next_src = spread_src_o;
        next_sw = spread_sw_o;
        next_ref_oe = ref_oe_o;
        next_ref_keep = ref_keep_o;
        next_ref_rate = ref_rate_o;
        next_slew = slew_o;
        if (wr_en_i) begin
            case (wr_idx_i)
                IDX_EN_LO: next_en[7:0] = wr_data_i;
                IDX_EN_HI: next_en[11:8] = wr_data_i[EN_HI_LSB +: 4];
                IDX_REF_CTRL: begin
                    next_src = wr_data_i[SPREAD_SRC_BIT];
                    next_sw = wr_data_i[SPREAD_SW_LSB +: 2];
                    next_ref_oe = wr_data_i[REF_OE_BIT];
                    next_ref_keep = wr_data_i[REF_KEEP_BIT];
                    next_ref_rate = wr_data_i[REF_RATE_LSB +: 2];
                end
                IDX_SLEW: next_slew = wr_data_i;
                default: next_en = en_o;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            en_o <= {EN_HI_RST, EN_LO_RST};
            spread_src_o <= SPREAD_SRC_RST;
            spread_sw_o <= SPREAD_SW_RST;
            ref_oe_o <= REF_OE_RST;
            ref_keep_o <= REF_KEEP_RST;
            ref_rate_o <= REF_RATE_RST;
            slew_o <= SLEW_RST;
        end else begin
            en_o <= next_en;
            spread_src_o <= next_src;
            spread_sw_o <= next_sw;
            ref_oe_o <= next_ref_oe;
            ref_keep_o <= next_ref_keep;
            ref_rate_o <= next_ref_rate;
            slew_o <= next_slew;
        end
    end

    // read mux; unmapped bytes and reserved bits read zero
    always_comb begin
        case (rd_idx_i)
            IDX_EN_LO: rd_data_o = en_o[7:0];
            IDX_EN_HI: rd_data_o = {en_o[11:8], 2'h0, spread_pin_i};
            IDX_REF_CTRL: rd_data_o = {spread_src_o, spread_sw_o, 1'h0, ref_oe_o, ref_keep_o, ref_rate_o};
            IDX_SLEW: rd_data_o = slew_o;
            default: rd_data_o = 8'h00;
        endcase
    end

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd_idx_i == IDX_EN_HI) |-> (rd_data_o[3:2] == 2'h0))
        else $error("reserved bits of byte 1 read nonzero");
endmodule : cgsr_regs

/* tb/cgsr_host.sv */
// host controller model driving the two-wire bus
`timescale 1ns/100ps
module cgsr_host (
    // clock
    input wire logic clk_i,
    // bus lines, data low while sda_low_o is high
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    localparam int Q = 10; // quarter bit keeps setup and hold above 8 clk
    // idle bus, both lines released high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask : w
    // start or repeated start, leaves scl low
    task automatic start();
        w(Q);
        sda_low_o = 1'b0;
        w(Q);
        scl_o = 1'b1;
        w(2 * Q);
        sda_low_o = 1'b1;
        w(2 * Q);
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        w(Q);
        sda_low_o = 1'b1;
        w(Q);
        scl_o = 1'b1;
        w(2 * Q);
        sda_low_o = 1'b0;
        w(2 * Q);
    endtask : stop
    // nine bits msb first; a 1 releases the line so the target may answer
    task automatic x9(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            w(Q);
            sda_low_o = !d[i];
            w(Q);
            scl_o = 1'b1;
            w(Q);
            r[i] = sda_i;
            w(Q);
            scl_o = 1'b0;
        end
    endtask : x9
endmodule : cgsr_host

/* tb/tb_top.sv */
// testbench for the clock generator serial control block
`timescale 1ns/100ps
module tb_top import cgsr_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    logic [1:0] ss_pin = 2'b01;
    logic oe_pin_n = 1'b0;
    logic pd_n = 1'b1;
    logic scl, host_low, sda_o, sda_oe, ref_en;
    logic [11:0] out_en;
    logic [7:0] fast;
    logic [1:0] ss_code, ref_rate;
    int fails = 0;
    int cmp_count = 0;
    logic [7:0] rd_exp [5] = '{8'h04, 8'h0F, 8'h51, 8'hEF, 8'hFF};
    logic [7:0] rst_exp [4] = '{8'hFF, 8'hF1, 8'h29, 8'hFF};
    logic [8:0] r;
    wire sda = !(sda_oe | host_low); // pull-up on the open-drain line
    // 200 MHz clock
    always #2.5 clk = !clk;
    cgsr_top u_cgsr_top (.clk_i(clk), .reset_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .addr_strap_i(strap), .spread_pin_i(ss_pin), .output_enable_pin_n_i(oe_pin_n),
        .power_down_n_i(pd_n), .pcie_out_en_o(out_en), .pcie_edge_fast_o(fast), .spread_code_o(ss_code),
        .refclk_en_o(ref_en), .refclk_edge_rate_o(ref_rate));
    cgsr_host u_cgsr_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic send(input logic [7:0] d);
        logic [8:0] a;
        u_cgsr_host.x9({d, 1'b1}, a);
        chk(a[0], 1'b0);
    endtask : send
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        u_cgsr_host.start();
        send(8'hD2);
        send({1'b1, idx});
        send(d);
        u_cgsr_host.stop();
    endtask : wr
    task automatic rd(input logic [6:0] idx, input logic [7:0] e);
        u_cgsr_host.start();
        send(8'hD2);
        send({1'b1, idx});
        u_cgsr_host.start();
        send(8'hD3);
        u_cgsr_host.x9(9'h1FF, r);
        chk(r[8:1], e);
        u_cgsr_host.stop();
    endtask : rd
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // watchdog sized well above the expected run
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(out_en, 12'hFFF);
        chk(fast, 8'hFF);
        chk(ref_en, 1'b1);
        chk(ref_rate, 2'b01);
        chk(ss_code, 2'b01);
        chk(sda_o, 1'b0);
        strap = 1'b1; // later strap and pin moves must be ignored
        ss_pin = 2'b11;
        for (int i = 0; i < 4; i++) rd(7'(i), rst_exp[i]);
        rd(7'h10, 8'h00);
        wr(1, 8'hFF);
        wr(2, 8'hFF);
        rd(1, 8'hF1);
        rd(2, 8'hEF);
        repeat (10) @(negedge clk);
        chk(ss_code, 2'b11);
        chk(ref_rate, 2'b11);
        u_cgsr_host.start();
        send(8'hD2);
        send(8'h00);
        send(8'h02);
        send(8'h0F);
        send(8'h5A);
        u_cgsr_host.stop();
        u_cgsr_host.start();
        send(8'hD2);
        send(8'h00);
        u_cgsr_host.start();
        send(8'hD3);
        for (int i = 0; i < 5; i++) begin
            u_cgsr_host.x9({8'hFF, i == 4}, r);
            chk(r[8:1], rd_exp[i]);
        end
        u_cgsr_host.stop();
        chk(out_en, 12'h50F);
        u_cgsr_host.start();
        // strap-one address with write; the strap moved after capture, so no ack
        u_cgsr_host.x9(9'h1A9, r);
        chk(r[0], 1'b1);
        u_cgsr_host.stop();
        pd_n = 1'b0;
        repeat (10) @(negedge clk);
        chk(out_en, 12'h000);
        chk(ref_en, 1'b1);
        pd_n = 1'b1;
        oe_pin_n = 1'b1;
        repeat (10) @(negedge clk);
        chk(out_en, 12'h000);
        // keep bit cleared: power-down must stop the reference
        wr(2, 8'hEB);
        pd_n = 1'b0;
        repeat (10) @(negedge clk);
        chk(ref_en, 1'b0);
        // second power-up with strap high: the other address answers
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(ss_code, 2'b11);
        u_cgsr_host.start();
        u_cgsr_host.x9(9'h1A9, r);
        chk(r[0], 1'b0);
        u_cgsr_host.stop();
        give_verdict();
    end
endmodule : tb_top
